// >>> design/spm_pkg.sv
// Purpose: Shared constants and types for the program-store sequencer
// Assumes: 8-bit register bus, 16-bit Z pointer, one 20 MHz clock
// Notes:   Lock bits read 1 when unprogrammed, 0 when programmed
package spm_pkg;

  // Register location
  localparam logic [7:0] CSR_DATA_ADDR = 8'h57;
  localparam logic [7:0] CSR_IO_OFFSET = 8'h20;
  localparam logic [7:0] CSR_IO_ADDR   = CSR_DATA_ADDR - CSR_IO_OFFSET;
  localparam logic [7:0] CSR_RESET     = 8'h00;

  // Field positions of program_store_ctrl_status
  localparam int unsigned BIT_IRQ_EN = 7;
  localparam int unsigned BIT_BUSY   = 6;
  localparam int unsigned BIT_SIG    = 5;
  localparam int unsigned BIT_REEN   = 4;
  localparam int unsigned BIT_BLB    = 3;
  localparam int unsigned BIT_WRT    = 2;
  localparam int unsigned BIT_ERS    = 1;
  localparam int unsigned BIT_EN     = 0;

  // Command patterns in bits 5:0; all but PAT_NONE are accepted
  localparam logic [5:0] PAT_SIG  = 6'h21;
  localparam logic [5:0] PAT_REEN = 6'h11;
  localparam logic [5:0] PAT_BLB  = 6'h09;
  localparam logic [5:0] PAT_WRT  = 6'h05;
  localparam logic [5:0] PAT_ERS  = 6'h03;
  localparam logic [5:0] PAT_FILL = 6'h01;
  localparam logic [5:0] PAT_NONE = 6'h00;

  // Arming windows in clock cycles
  localparam int unsigned STORE_WIN_CYC = 4;
  localparam int unsigned LOAD_WIN_CYC  = 3;

  // Lock byte
  localparam logic [7:0] LOCK_RESET     = 8'hFF;
  localparam logic [7:0] LOCK_MASK_BOOT = 8'h3F;
  localparam logic [7:0] LOCK_MASK_NONE = 8'h03;
  localparam int unsigned LB_BIT0 = 0;
  localparam int unsigned LB_BIT1 = 1;

  // Flash addressing widths
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned WORD_W = 7;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b10
  } seq_state_e;

  typedef struct packed
  {
    logic              buf_load;
    logic              buf_discard;
    logic              page_erase;
    logic              page_write;
    logic              lock_prog;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] word;
    logic [15:0]       data;
  } flash_cmd_s;

  typedef struct packed
  {
    logic ext_prog_block;
    logic ext_verify_block;
    logic fuse_locked;
    logic bootlock_locked;
  } lock_prot_s;

endpackage : spm_pkg

// >>> design/arm_window.sv
// Purpose: Counts an arming window of LEN cycles after a start pulse
// Assumes: Start and stop come from logic on the same clock
// Notes:   Active in the LEN cycles following the start edge
`timescale 1ns/1ps
module arm_window #(
  parameter int unsigned LEN = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic stop,
  output logic      active,
  output logic      expire
);

  logic [3:0] cnt_r;

  // Reload on start, drop on stop, otherwise count down
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_r <= 4'h0;
    else if (start)
      cnt_r <= 4'(LEN);
    else if (stop)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  // Window flags
  assign active = (cnt_r != 4'h0);
  assign expire = (cnt_r == 4'h1) & ~start & ~stop;

endmodule : arm_window

// >>> design/lock_bit_store.sv
// Purpose: Holds boot and memory lock bits and decodes protection
// Assumes: nv_lock carries the stored lock byte while rst is high
// Notes:   Bits only move towards programmed except on chip erase
`timescale 1ns/1ps
module lock_bit_store
  import spm_pkg::*;
#(
  parameter bit BOOT_SECTION = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  nv_lock,
  input  wire logic        chip_erase,
  input  wire logic        prog_en,
  input  wire logic [7:0]  prog_data,
  output logic [7:0]       lock_r,
  output spm_pkg::lock_prot_s prot_r
);

  logic [7:0] impl_mask;
  logic       lb0_prog;
  logic       lb1_prog;

  assign impl_mask = BOOT_SECTION ? LOCK_MASK_BOOT : LOCK_MASK_NONE;
  assign lb0_prog  = ~lock_r[LB_BIT0];
  assign lb1_prog  = ~lock_r[LB_BIT1];

  // Lock byte: reload stored value, erase only by chip erase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      lock_r <= nv_lock | ~impl_mask;
    else if (chip_erase)
      lock_r <= LOCK_RESET;
    else if (prog_en)
      lock_r <= lock_r & (prog_data | ~impl_mask);
  end

  // Protection modes 1, 2 and 3 from the memory lock pair
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prot_r <= '0;
    else
    begin
      prot_r.ext_prog_block   <= lb0_prog | lb1_prog;
      prot_r.fuse_locked      <= lb0_prog | lb1_prog;
      prot_r.ext_verify_block <= lb0_prog & lb1_prog;
      prot_r.bootlock_locked  <= lb0_prog & lb1_prog;
    end
  end

  a_lock_one_way : assert property (@(posedge sys_clk) disable iff (rst)
    !chip_erase |=> ((lock_r & ~$past(lock_r)) == 8'h00))
    else $error("lock bit returned to unprogrammed without chip erase");

endmodule : lock_bit_store

// >>> design/self_program_store_control.sv
// Purpose: Control and status register and sequencer for flash self-programming
// Assumes: CPU strobes store_instr and load_instr for one cycle; flash_done
//          pulses when the array finishes an erase or write
// Notes:   Register reads answer one cycle after the read strobe
// Notes on behaviour
// - Register answers at data address 0x57 and I/O address 0x37.
// - Ready interrupt requested while enable, global flag set and store enable clear.
// - Erase or write to readable section sets busy flag, blocking reads.
// - Busy flag clears on re-enable command or on a buffer load.
// - Signature read: load returns signature byte; store does nothing.
// - Re-enable makes readable section accessible; refused while programming runs.
// - Writing re-enable during buffer filling discards the buffered data.
// - Lock write programs lock bits from R0, then self-clears.
// - Lock write armed: load returns lock or fuse byte by Z bit 0.
// - Page write writes buffer to page from upper Z bits, then clears.
// - Page write to non-readable section halts the CPU throughout.
// - Page erase erases page from upper Z bits, then clears.
// - Store enable alone: store loads R1:R0 into buffer at Z word.
// - Store enable arms four cycles, clears after use, holds during programming.
// - Other patterns in the lower control bits have no effect.
// - Lock bits read one unprogrammed, zero programmed, default unprogrammed.
// - Only chip erase returns lock bits to unprogrammed.
// - Without boot section, store works only with self-programming fuse programmed.
// - Lock mode 1 applies no protection.
// - Lock mode 2 refuses external programming and locks fuses.
// - Lock mode 3 also refuses verification and locks boot lock bits.
`timescale 1ns/1ps
module self_program_store_control
  import spm_pkg::*;
#(
  parameter bit                BOOT_SECTION    = 1'b1,
  parameter int unsigned       Z_PAGE_LSB      = 6,
  parameter logic [PAGE_W-1:0] HALT_FIRST_PAGE = 8'h60
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          io_addr,
  input  wire logic                io_space,
  input  wire logic                io_wr,
  input  wire logic                io_rd,
  input  wire logic [7:0]          io_wdata,
  output logic [7:0]               io_rdata_r,
  input  wire logic                store_instr,
  input  wire logic                load_instr,
  input  wire logic [15:0]         z_ptr,
  input  wire logic [7:0]          r0,
  input  wire logic [7:0]          r1,
  input  wire logic                global_irq_flag,
  input  wire logic                self_programming_fuse,
  input  wire logic [7:0]          fuse_low_byte,
  input  wire logic [7:0]          sig_row_byte,
  input  wire logic [7:0]          nv_lock,
  input  wire logic                chip_erase,
  input  wire logic                flash_done,
  output logic                     irq_req_r,
  output logic                     section_busy_flag_r,
  output logic                     cpu_halt_r,
  output logic [7:0]               load_data_r,
  output logic                     load_valid_r,
  output spm_pkg::flash_cmd_s      flash_cmd_r,
  output logic [7:0]               lock_bits_r,
  output spm_pkg::lock_prot_s      lock_prot_r
);

  seq_state_e        state_r;
  seq_state_e        state_nxt;
  logic [5:0]        mode_r;
  logic [5:0]        mode_nxt;
  logic              irq_en_r;
  logic              busy_nxt;
  logic              halt_nxt;
  logic              buf_dirty_r;
  logic              reg_hit;
  logic              csr_wr;
  logic              pat_ok;
  logic              write_ok;
  logic              armed;
  logic              store_hit;
  logic              load_hit;
  logic              spm_allowed;
  logic              fill_hit;
  logic              reen_hit;
  logic              blb_hit;
  logic              ers_hit;
  logic              wrt_hit;
  logic              op_start;
  logic              discard;
  logic              to_halt_sec;
  logic              st_act;
  logic              st_exp;
  logic              ld_act;
  logic [7:0]        csr_val;
  logic [7:0]        load_sel;
  logic [15:0]       word_mask;
  logic [PAGE_W-1:0] z_page;
  logic [WORD_W-1:0] z_word;
  flash_cmd_s        cmd_nxt;

  // Address decode for both addressing styles
  assign reg_hit = io_space ? (io_addr == CSR_IO_ADDR)
                            : (io_addr == CSR_DATA_ADDR);
  assign csr_wr  = io_wr & reg_hit;

  // Only the listed command patterns arm the sequencer
  assign pat_ok   = io_wdata[5:0] inside {PAT_SIG, PAT_REEN, PAT_BLB,
                                          PAT_WRT, PAT_ERS, PAT_FILL};
  assign write_ok = csr_wr & pat_ok & (state_r != ST_BUSY);

  // Instruction qualification inside the arming windows
  assign armed       = (state_r == ST_ARMED);
  assign store_hit   = store_instr & armed & st_act;
  assign load_hit    = load_instr & armed & ld_act
                     & (mode_r[BIT_SIG] | mode_r[BIT_BLB]);
  assign spm_allowed = BOOT_SECTION | ~self_programming_fuse;
  assign fill_hit    = store_hit & spm_allowed & (mode_r == PAT_FILL);
  assign reen_hit    = store_hit & spm_allowed & (mode_r == PAT_REEN);
  assign blb_hit     = store_hit & spm_allowed & (mode_r == PAT_BLB);
  assign ers_hit     = store_hit & spm_allowed & (mode_r == PAT_ERS);
  assign wrt_hit     = store_hit & spm_allowed & (mode_r == PAT_WRT);
  assign op_start    = ers_hit | wrt_hit;
  assign discard     = write_ok & io_wdata[BIT_REEN] & buf_dirty_r;

  // Page and word fields of the Z pointer; bit 0 is not used by stores
  assign word_mask = (16'h0001 << (Z_PAGE_LSB - 1)) - 16'h0001;
  assign z_page    = PAGE_W'(z_ptr >> Z_PAGE_LSB);
  assign z_word    = WORD_W'((z_ptr >> 1) & word_mask);
  assign to_halt_sec = (z_page >= HALT_FIRST_PAGE);

  // Register image and load-instruction data selection
  assign csr_val  = {irq_en_r, section_busy_flag_r, mode_r};
  assign load_sel = mode_r[BIT_SIG] ? sig_row_byte
                  : (z_ptr[0] ? fuse_low_byte : lock_bits_r);

  // Commands towards the flash array, all one-cycle pulses
  assign cmd_nxt.buf_load    = fill_hit;
  assign cmd_nxt.buf_discard = discard;
  assign cmd_nxt.page_erase  = ers_hit;
  assign cmd_nxt.page_write  = wrt_hit;
  assign cmd_nxt.lock_prog   = blb_hit;
  assign cmd_nxt.page        = z_page;
  assign cmd_nxt.word        = z_word;
  assign cmd_nxt.data        = {r1, r0};

  // Store window of four cycles, load window of three
  arm_window #(
    .LEN    (STORE_WIN_CYC)
  ) u_store_win (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (write_ok),
    .stop    (store_hit),
    .active  (st_act),
    .expire  (st_exp)
  );

  arm_window #(
    .LEN    (LOAD_WIN_CYC)
  ) u_load_win (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (write_ok),
    .stop    (store_hit),
    .active  (ld_act),
    .expire  ()
  );

  // Lock byte and protection decode
  lock_bit_store #(
    .BOOT_SECTION (BOOT_SECTION)
  ) u_lock (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .nv_lock    (nv_lock),
    .chip_erase (chip_erase),
    .prog_en    (blb_hit),
    .prog_data  (r0),
    .lock_r     (lock_bits_r),
    .prot_r     (lock_prot_r)
  );

  // Sequencer: arm, run one command, hold during programming
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    unique case (state_r)
      ST_IDLE:
        if (write_ok)
        begin
          state_nxt = ST_ARMED;
          mode_nxt  = io_wdata[5:0];
        end
      ST_ARMED:
        if (op_start)
          state_nxt = ST_BUSY;
        else if (store_hit)
        begin
          state_nxt = ST_IDLE;
          mode_nxt  = PAT_NONE;
        end
        else if (write_ok)
          mode_nxt = io_wdata[5:0];
        else if (st_exp)
        begin
          state_nxt = ST_IDLE;
          mode_nxt  = PAT_NONE;
        end
      ST_BUSY:
        if (flash_done)
        begin
          state_nxt = ST_IDLE;
          mode_nxt  = PAT_NONE;
        end
      default:
      begin
        state_nxt = ST_IDLE;
        mode_nxt  = PAT_NONE;
      end
    endcase
  end

  // Busy flag: a new erase or write wins over any clear
  assign busy_nxt = (op_start & ~to_halt_sec) ? 1'b1
                  : (fill_hit | reen_hit) ? 1'b0
                  : section_busy_flag_r;

  // CPU halt for erase or write aimed at the non-readable section
  assign halt_nxt = (op_start & to_halt_sec) ? 1'b1
                  : (state_r == ST_BUSY && flash_done) ? 1'b0
                  : cpu_halt_r;

  // Sequencer and status flops
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r             <= ST_IDLE;
      mode_r              <= CSR_RESET[5:0];
      irq_en_r            <= CSR_RESET[BIT_IRQ_EN];
      section_busy_flag_r <= CSR_RESET[BIT_BUSY];
      cpu_halt_r          <= 1'b0;
    end
    else
    begin
      state_r             <= state_nxt;
      mode_r              <= mode_nxt;
      irq_en_r            <= csr_wr ? io_wdata[BIT_IRQ_EN] : irq_en_r;
      section_busy_flag_r <= busy_nxt;
      cpu_halt_r          <= halt_nxt;
    end
  end

  // Buffer contents tracking for discard on re-enable
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      buf_dirty_r <= 1'b0;
    else if (fill_hit)
      buf_dirty_r <= 1'b1;
    else if (discard || (state_r == ST_BUSY && flash_done))
      buf_dirty_r <= 1'b0;
  end

  // Bus answers, interrupt request, load data and flash commands
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      io_rdata_r   <= 8'h00;
      irq_req_r    <= 1'b0;
      load_data_r  <= 8'h00;
      load_valid_r <= 1'b0;
      flash_cmd_r  <= '0;
    end
    else
    begin
      io_rdata_r   <= (io_rd & reg_hit) ? csr_val : 8'h00;
      irq_req_r    <= irq_en_r & global_irq_flag & ~mode_r[BIT_EN];
      load_data_r  <= load_hit ? load_sel : load_data_r;
      load_valid_r <= load_hit;
      flash_cmd_r  <= cmd_nxt;
    end
  end

  sequence s_armed_quiet;
    write_ok ##1 (!store_instr && !io_wr)[*4];
  endsequence

  a_irq_level : assert property (@(posedge sys_clk) disable iff (rst)
    (irq_en_r && global_irq_flag && !mode_r[BIT_EN]) |=> irq_req_r)
    else $error("ready interrupt not requested");

  a_arm_expire : assert property (@(posedge sys_clk) disable iff (rst)
    s_armed_quiet |=> (mode_r == PAT_NONE))
    else $error("store enable did not clear after four idle cycles");

  a_bad_pattern : assert property (@(posedge sys_clk) disable iff (rst)
    (csr_wr && !pat_ok && state_r == ST_IDLE) |=> $stable(mode_r))
    else $error("invalid pattern changed control bits");

  a_busy_set : assert property (@(posedge sys_clk) disable iff (rst)
    (op_start && !to_halt_sec) |=> section_busy_flag_r && state_r == ST_BUSY)
    else $error("busy flag not set by readable section programming");

  a_busy_clear : assert property (@(posedge sys_clk) disable iff (rst)
    (fill_hit || reen_hit) |=> !section_busy_flag_r && flash_cmd_r.buf_load == $past(fill_hit))
    else $error("busy flag not cleared by load or re-enable");

  a_halt_hold : assert property (@(posedge sys_clk) disable iff (rst)
    (op_start && to_halt_sec) |=> cpu_halt_r throughout (state_r == ST_BUSY)[*1])
    else $error("cpu not halted for non-readable programming");

  a_enable_hold : assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_BUSY && !flash_done) |=> mode_r[BIT_EN])
    else $error("store enable dropped during programming");

  a_lock_read : assert property (@(posedge sys_clk) disable iff (rst)
    (load_hit && mode_r == PAT_BLB && !z_ptr[0])
      |=> load_valid_r && load_data_r == $past(lock_bits_r))
    else $error("load did not return lock bits");

  a_spm_disabled : assert property (@(posedge sys_clk) disable iff (rst)
    (store_instr && !spm_allowed)
      |=> !flash_cmd_r.page_erase && !flash_cmd_r.page_write && !flash_cmd_r.buf_load)
    else $error("store acted while self-programming disabled");

  a_discard : assert property (@(posedge sys_clk) disable iff (rst)
    (write_ok && io_wdata[BIT_REEN] && buf_dirty_r) |=> flash_cmd_r.buf_discard ##1 !buf_dirty_r[*1])
    else $error("buffer not discarded by re-enable write");

endmodule : self_program_store_control

// >>> tb/cpu_core_model.sv
// Purpose: CPU core model issuing program-store and program-load instructions
// Assumes: Each instruction is a one-cycle strobe launched just after a rising edge
// Notes:   Lead cycles let a caller issue promptly or let an arming window lapse
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] load_data_r,
  output logic            store_instr,
  output logic            load_instr,
  output logic [15:0]     z_ptr,
  output logic [7:0]      r0,
  output logic [7:0]      r1
);
  // Quiet instruction lines from time zero
  initial
  begin
    store_instr = 1'b0;
    load_instr  = 1'b0;
    z_ptr       = 16'h0000;
    r0          = 8'h00;
    r1          = 8'h00;
  end

  // Store: operands held to the taken edge, then scrambled so stale values never match
  task automatic store_op(input int lead, input logic [15:0] z, input logic [7:0] hi, lo);
    repeat (lead) @(posedge sys_clk);
    @(posedge sys_clk);
    store_instr <= 1'b1;
    z_ptr       <= {z[15:1], 1'b0};
    r1          <= hi;
    r0          <= lo;
    @(posedge sys_clk);
    store_instr <= 1'b0;
    z_ptr       <= ~z;
    r1          <= ~hi;
    r0          <= ~lo;
  endtask : store_op

  // Load: bit 0 of the pointer picks the byte; result taken half a cycle later
  task automatic load_op(input int lead, input logic [15:0] z, output logic [7:0] d);
    repeat (lead) @(posedge sys_clk);
    @(posedge sys_clk);
    load_instr <= 1'b1;
    z_ptr      <= z;
    @(posedge sys_clk);
    load_instr <= 1'b0;
    z_ptr      <= ~z;
    @(negedge sys_clk);
    d = load_data_r;
  endtask : load_op
endmodule : cpu_core_model

// >>> tb/self_program_store_control_bench.sv
// Purpose: Self-checking bench for the program-store control block
// Assumes: Register strobes and instructions launched at rising edges
// Notes:   Command pulses are gathered in sticky flags so checks do not race
`timescale 1ns/1ps
module self_program_store_control_bench;
  import spm_pkg::*;
  logic                sys_clk, rst, io_space, io_wr, io_rd, clr_r;
  logic                global_irq_flag, chip_erase, flash_done;
  logic [7:0]          io_addr, io_wdata, io_rdata_r, load_data_r, lock_bits_r, r0, r1, d;
  logic                store_instr, load_instr, irq_req_r, section_busy_flag_r;
  logic                cpu_halt_r, load_valid_r;
  logic [15:0]         z_ptr;
  logic [5:0]          seen_r;
  flash_cmd_s          flash_cmd_r, last_r;
  lock_prot_s          lock_prot_r;
  int                  bad_count = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  logic [7:0]          lk_in [3] = '{8'hFE, 8'hFC, 8'hFF};
  logic [7:0]          lk_ex [3] = '{8'hFE, 8'hFC, 8'hFC};
  logic [3:0]          pr_ex [3] = '{4'hA, 4'hF, 4'hF};
  logic [7:0]          bad_pat [4] = '{8'h07, 8'h02, 8'h31, 8'h19};
  logic [7:0]          nr_pat [2] = '{8'h05, 8'h03};

  self_program_store_control self_program_store_control_i (
    .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_space(io_space),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
    .store_instr(store_instr), .load_instr(load_instr), .z_ptr(z_ptr), .r0(r0), .r1(r1),
    .global_irq_flag(global_irq_flag), .self_programming_fuse(1'b0),
    .fuse_low_byte(8'h62), .sig_row_byte(8'h3C), // Arbitrary byte values
    .nv_lock(8'hFF), .chip_erase(chip_erase), .flash_done(flash_done),
    .irq_req_r(irq_req_r), .section_busy_flag_r(section_busy_flag_r),
    .cpu_halt_r(cpu_halt_r), .load_data_r(load_data_r), .load_valid_r(load_valid_r),
    .flash_cmd_r(flash_cmd_r), .lock_bits_r(lock_bits_r), .lock_prot_r(lock_prot_r)
  );

  cpu_core_model cpu_core_model_i (
    .sys_clk(sys_clk), .load_data_r(load_data_r), .store_instr(store_instr),
    .load_instr(load_instr), .z_ptr(z_ptr), .r0(r0), .r1(r1)
  );

  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Sticky record of command and load pulses, last buffer load, erase or write command kept
  always @(posedge sys_clk)
  begin
    seen_r <= clr_r ? 6'h00 : seen_r | {flash_cmd_r.buf_load, flash_cmd_r.buf_discard,
                                        flash_cmd_r.page_erase, flash_cmd_r.page_write,
                                        flash_cmd_r.lock_prog, load_valid_r};
    if (flash_cmd_r.buf_load || flash_cmd_r.page_erase || flash_cmd_r.page_write)
      last_r <= flash_cmd_r;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic s, input logic [7:0] v);
    @(posedge sys_clk);
    io_wr    <= 1'b1;
    io_addr  <= a;
    io_space <= s;
    io_wdata <= v;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    io_wdata <= ~v;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic s, output logic [7:0] v);
    @(posedge sys_clk);
    io_rd    <= 1'b1;
    io_addr  <= a;
    io_space <= s;
    @(posedge sys_clk);
    io_rd    <= 1'b0;
    @(negedge sys_clk);
    v = io_rdata_r;
  endtask : rd

  task automatic chk_reg(input logic [7:0] exp);
    logic [7:0] v;
    rd(8'h57, 1'b0, v);
    check("csr", v, exp);
  endtask : chk_reg

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic clear_seen;
    @(posedge sys_clk);
    clr_r <= 1'b1;
    @(posedge sys_clk);
    clr_r <= 1'b0;
  endtask : clear_seen

  task automatic done_pulse;
    @(posedge sys_clk);
    flash_done <= 1'b1;
    @(posedge sys_clk);
    flash_done <= 1'b0;
  endtask : done_pulse

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {io_space, io_wr, io_rd, clr_r, global_irq_flag, chip_erase, flash_done} = '0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    chk_reg(8'h00);
    check("lock", lock_bits_r, 8'hFF);
    check("prot", lock_prot_r, 4'h0);
    // Both address views and near misses
    wr(8'h37, 1'b1, 8'h80);
    rd(8'h37, 1'b1, d);
    check("io", d, 8'h80);
    rd(8'h37, 1'b0, d);
    check("miss37", d, 8'h00);
    rd(8'h58, 1'b0, d);
    check("miss58", d, 8'h00);
    // Ready request follows enable, global flag and store enable
    @(posedge sys_clk);
    global_irq_flag <= 1'b1;
    settle();
    check("irq", irq_req_r, 1'b1);
    wr(8'h57, 1'b0, 8'h81);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("irq_armed", irq_req_r, 1'b0);
    settle();
    chk_reg(8'h80);
    check("irq_back", irq_req_r, 1'b1);
    @(posedge sys_clk);
    global_irq_flag <= 1'b0;
    // Store in cycle five after arming is refused
    clear_seen();
    wr(8'h57, 1'b0, 8'h01);
    cpu_core_model_i.store_op(3, 16'h0086, 8'h11, 8'h22);
    settle();
    check("late", seen_r[5], 1'b0);
    chk_reg(8'h00);
    // Erase in readable section, re-enable refused while busy
    clear_seen();
    wr(8'h57, 1'b0, 8'h03);
    cpu_core_model_i.store_op(0, 16'h0086, 8'h11, 8'h22);
    settle();
    check("erase", seen_r[3], 1'b1);
    check("epage", last_r.page, 8'h02);
    check("busy", section_busy_flag_r, 1'b1);
    chk_reg(8'h43);
    wr(8'h57, 1'b0, 8'h11);
    chk_reg(8'h43);
    done_pulse();
    settle();
    chk_reg(8'h40);
    // Fill in cycle four clears busy and carries R1:R0
    clear_seen();
    wr(8'h57, 1'b0, 8'h01);
    cpu_core_model_i.store_op(2, 16'h0086, 8'hA5, 8'h3C);
    settle();
    check("fill", seen_r[5], 1'b1);
    check("word", last_r.word, 7'h03);
    check("data", last_r.data, 16'hA53C);
    check("busy_fill", section_busy_flag_r, 1'b0);
    chk_reg(8'h00);
    // Re-enable write while filled drops the buffer
    wr(8'h57, 1'b0, 8'h11);
    settle();
    check("discard", seen_r[4], 1'b1);
    // Page write in readable section, busy held until re-enable
    clear_seen();
    wr(8'h57, 1'b0, 8'h05);
    cpu_core_model_i.store_op(0, 16'h0080, 8'h11, 8'h22);
    settle();
    check("write", seen_r[2], 1'b1);
    check("wpage", last_r.page, 8'h02);
    done_pulse();
    settle();
    check("busy_held", section_busy_flag_r, 1'b1);
    wr(8'h57, 1'b0, 8'h11);
    cpu_core_model_i.store_op(0, 16'h0000, 8'h11, 8'h22);
    settle();
    check("reenable", section_busy_flag_r, 1'b0);
    // Write and erase of the non-readable section halt the CPU
    foreach (nr_pat[i])
    begin
      wr(8'h57, 1'b0, nr_pat[i]);
      cpu_core_model_i.store_op(0, 16'h1800, 8'h11, 8'h22);
      settle();
      check("halt", cpu_halt_r, 1'b1);
      check("npage", last_r.page, 8'h60);
      done_pulse();
      settle();
      check("unhalt", cpu_halt_r, 1'b0);
      chk_reg(8'h00);
    end
    // Rejected patterns leave the register and the array alone
    clear_seen();
    foreach (bad_pat[i])
    begin
      wr(8'h57, 1'b0, bad_pat[i]);
      cpu_core_model_i.store_op(0, 16'h0080, 8'h11, 8'h22);
      chk_reg(8'h00);
    end
    check("no_cmd", seen_r, 6'h00);
    // Lock writes only program bits; R1 and Z ignored
    foreach (lk_in[i])
    begin
      wr(8'h57, 1'b0, 8'h09);
      cpu_core_model_i.store_op(0, 16'h1234, 8'h00, lk_in[i]);
      settle();
      check("lock_w", lock_bits_r, lk_ex[i]);
      check("prot_w", lock_prot_r, pr_ex[i]);
      check("lprog", seen_r[1], 1'b1);
      chk_reg(8'h00);
    end
    // Loads read lock, fuse and signature bytes; store in signature mode is inert
    wr(8'h57, 1'b0, 8'h09);
    cpu_core_model_i.load_op(0, 16'h0000, d);
    check("ld_lock", d, 8'hFC);
    wr(8'h57, 1'b0, 8'h09);
    cpu_core_model_i.load_op(0, 16'h0001, d);
    check("ld_fuse", d, 8'h62);
    clear_seen();
    wr(8'h57, 1'b0, 8'h21);
    cpu_core_model_i.load_op(1, 16'h0000, d);
    check("ld_sig", d, 8'h3C);
    wr(8'h57, 1'b0, 8'h21);
    cpu_core_model_i.store_op(0, 16'h0080, 8'h11, 8'h22);
    settle();
    check("sig_store", seen_r, 6'h01);
    // Chip erase alone restores the lock byte
    @(posedge sys_clk);
    chip_erase <= 1'b1;
    @(posedge sys_clk);
    chip_erase <= 1'b0;
    settle();
    check("erased", lock_bits_r, 8'hFF);
    check("prot_free", lock_prot_r, 4'h0);
    tally_and_finish();
  end
endmodule : self_program_store_control_bench
